// ---- rtl/flash_decode_pkg.sv ----
// Purpose: shared constants for the serial flash command/address decoder
// Assumes: 25 MHz system clock, 528-byte page addressing
// Notes:   opcodes, field positions and power-up timing
package flash_decode_pkg;
  localparam int unsigned CLK_MHZ               = 25;
  localparam int unsigned SUPPLY_TO_SELECT_US   = 50;
  localparam int unsigned POWERUP_WRITE_MS      = 20;
  localparam int unsigned SUPPLY_TO_SELECT_CYC  = SUPPLY_TO_SELECT_US * CLK_MHZ;
  localparam int unsigned POWERUP_WRITE_CYC     = POWERUP_WRITE_MS * 1000 * CLK_MHZ;
  localparam int unsigned SCK_HALF_CYC          = 4;
  localparam int unsigned PAGE_W                = 12;
  localparam int unsigned BYTE_W                = 10;
  localparam int unsigned PAGE_MSB_POS          = 21;
  localparam int unsigned BYTE_MSB_POS          = 9;
  localparam int unsigned ADDR_BITS             = 24;
  localparam logic [3:0]  BLOCK_PAGE_BITS       = 4'h9;
  localparam logic [3:0]  SECTOR_PAGE_BITS      = 4'h4;
  localparam logic [7:0]  OP_READ_ARRAY         = 8'h03;
  localparam logic [7:0]  OP_FAST_READ          = 8'h0b;
  localparam logic [7:0]  OP_BLOCK_ERASE        = 8'h50;
  localparam logic [7:0]  OP_SECTOR             = 8'h7c;
  localparam logic [7:0]  OP_BUF1_WRITE         = 8'h84;
  localparam logic [7:0]  OP_BUF2_WRITE         = 8'h87;
  localparam logic [7:0]  OP_BUF1_READ_LF       = 8'hd1;
  localparam logic [7:0]  OP_PAGE_READ          = 8'hd2;
  localparam logic [7:0]  OP_BUF2_READ_LF       = 8'hd3;
  localparam logic [7:0]  OP_BUF1_READ          = 8'hd4;
  localparam logic [7:0]  OP_BUF2_READ          = 8'hd6;
  localparam logic [7:0]  OP_STATUS             = 8'hd7;
  localparam logic [7:0]  OP_LEGACY_READ        = 8'he8;
  localparam logic [7:0]  OP_ID_READ            = 8'h9f;
  localparam logic [7:0]  OP_DEEP_DOWN          = 8'hb9;
  localparam logic [7:0]  OP_RESUME             = 8'hab;
  localparam logic [2:0]  DUMMY_NONE            = 3'h0;
  localparam logic [2:0]  DUMMY_ONE             = 3'h1;
  localparam logic [2:0]  DUMMY_FOUR            = 3'h4;
endpackage

// ---- rtl/flash_link_if.sv ----
// Purpose: SPI link between host controller and flash decoder
// Assumes: released serial output reads high, as with a pull-up
// Notes:   one modport per party
`timescale 1ns/1ps
`default_nettype none
interface flash_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so_o;
  logic so_oe;
  wire  so;
  assign so = so_oe ? so_o : 1'b1;
  modport host (output cs_n, output sck, output si, input so);
  modport device (input cs_n, input sck, input si, output so_o, output so_oe);
endinterface
`default_nettype wire

// ---- rtl/flash_host_end.sv ----
// Purpose: SPI host that sends opcode, address and dummy bytes
// Assumes: mode 0 or 3 chosen by idle clock level input
// Notes:   clock generated by divider from mclk_i
`timescale 1ns/1ps
`default_nettype none
module flash_host_end #(
  parameter int unsigned SELECT_WAIT = flash_decode_pkg::SUPPLY_TO_SELECT_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  flash_link_if.host       link,
  input  wire logic        start_i,
  input  wire logic        idle_high_i,
  input  wire logic [7:0]  opcode_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [2:0]  dummy_i,
  output logic             ready_o,
  output logic             done_o
);
  typedef enum logic [1:0] {H_WAIT = 2'b00, H_IDLE = 2'b01, H_SHIFT = 2'b11, H_END = 2'b10} hstate_t;
  hstate_t     st_reg, st_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [63:0] sh_reg, sh_next;
  logic [6:0]  bits_reg, bits_next;
  logic [2:0]  half_reg, half_next;
  logic        sck_reg, sck_next, cs_reg, cs_next, idle_reg, idle_next, done_reg, done_next;
  logic        armed_reg, armed_next;

  always_comb begin
    st_next = st_reg; cnt_next = cnt_reg; sh_next = sh_reg; bits_next = bits_reg;
    half_next = half_reg; sck_next = sck_reg; cs_next = cs_reg; idle_next = idle_reg;
    done_next = 1'b0;
    armed_next = armed_reg;
    unique case (st_reg)
      H_WAIT: begin
        // hold select off after supply
        if (cnt_reg >= 16'(SELECT_WAIT)) st_next = H_IDLE;
        else cnt_next = cnt_reg + 16'h1;
      end
      H_IDLE: begin
        sck_next = idle_high_i;
        if (start_i && sck_reg == idle_high_i) begin
          idle_next = idle_high_i;
          armed_next = 1'b0;
          // opcode then address msb first, dummy bytes after
          sh_next   = {opcode_i, addr_i, 32'h0};
          bits_next = 7'(32 + 8 * int'(dummy_i));
          cs_next   = 1'b0; // falling edge opens the command
          half_next = 3'h0;
          st_next   = H_SHIFT;
        end
      end
      H_SHIFT: begin
        if (half_reg == 3'(flash_decode_pkg::SCK_HALF_CYC - 1)) begin
          half_next = 3'h0;
          sck_next  = ~sck_reg;
          if (!sck_reg) begin
            // rising edge: the device takes the bit now standing
            armed_next = 1'b1;
            bits_next  = bits_reg - 7'h1;
            if (bits_reg == 7'h1) st_next = H_END;
          end else if (armed_reg) begin
            // only a fall after a rise moves data; mode 3 opens with a bare fall
            sh_next = {sh_reg[62:0], 1'b0};
          end
        end else half_next = half_reg + 3'h1;
      end
      H_END: begin
        if (half_reg == 3'(flash_decode_pkg::SCK_HALF_CYC - 1)) begin
          sck_next = idle_reg; cs_next = 1'b1; done_next = 1'b1; st_next = H_IDLE;
        end else half_next = half_reg + 3'h1;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      st_reg <= H_WAIT; cnt_reg <= 16'h0; sh_reg <= 64'h0; bits_reg <= 7'h0; half_reg <= 3'h0;
      sck_reg <= 1'b1; cs_reg <= 1'b1; idle_reg <= 1'b1; done_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else if (ce_i) begin
      st_reg <= st_next; cnt_reg <= cnt_next; sh_reg <= sh_next; bits_reg <= bits_next;
      half_reg <= half_next; sck_reg <= sck_next; cs_reg <= cs_next; idle_reg <= idle_next;
      done_reg <= done_next;
      armed_reg <= armed_next;
    end
  end

  assign link.cs_n = cs_reg;
  assign link.sck  = sck_reg;
  assign link.si   = sh_reg[63];
  // select falls only once the clock already rests at the chosen idle level
  assign ready_o   = (st_reg == H_IDLE) && (sck_reg == idle_high_i);
  assign done_o    = done_reg;
endmodule
`default_nettype wire

// ---- rtl/flash_decode_dev.sv ----
// Purpose: device end: decodes opcode and 528-byte page address
// Assumes: link pins asynchronous, sampled by two flops
// Notes:   por_i models the internal power-on reset level
`timescale 1ns/1ps
`default_nettype none
module flash_decode_dev #(
  parameter int unsigned WRITE_WAIT = flash_decode_pkg::POWERUP_WRITE_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  input  wire logic        por_i,
  flash_link_if.device     link,
  output logic [7:0]       opcode_o,
  output logic [11:0]      page_o,
  output logic [9:0]       byte_o,
  output logic             cmd_valid_o,
  output logic             mode3_o,
  output logic             write_ok_o,
  output logic             standby_o
);
  typedef enum logic [1:0] {D_IDLE = 2'b00, D_OP = 2'b01, D_ADDR = 2'b11, D_DUMMY = 2'b10} dstate_t;
  logic [1:0]  cs_sync_reg, sck_sync_reg, si_sync_reg;
  logic [1:0]  cs_sync_next, sck_sync_next, si_sync_next;
  logic        cs_prev_reg, cs_prev_next, sck_prev_reg, sck_prev_next;
  dstate_t     st_reg, st_next;
  logic [23:0] sh_reg, sh_next;
  logic [5:0]  cnt_reg, cnt_next;
  logic [7:0]  op_reg, op_next;
  logic [2:0]  dummy_reg, dummy_next;
  logic [11:0] page_reg, page_next;
  logic [9:0]  byte_reg, byte_next;
  logic        valid_reg, valid_next, mode3_reg, mode3_next;
  logic [31:0] wcnt_reg, wcnt_next;
  logic        cs_fall, cs_rise, sck_rise, bit_in;
  logic [23:0] addr_full;
  logic [11:0] page_raw, page_mask;
  logic        op_no_addr;
  logic [1:0]  por_sync_reg, por_sync_next;

  ////////////////////////////////////////////////////////////
  always_comb begin
    por_sync_next = {por_sync_reg[0], por_i};
    cs_sync_next  = {cs_sync_reg[0], link.cs_n};
    sck_sync_next = {sck_sync_reg[0], link.sck};
    si_sync_next  = {si_sync_reg[0], link.si};
  end
  assign cs_fall  = cs_prev_reg & ~cs_sync_reg[1];
  assign cs_rise  = ~cs_prev_reg & cs_sync_reg[1];
  assign sck_rise = ~sck_prev_reg & sck_sync_reg[1] & ~cs_sync_reg[1];
  assign bit_in   = si_sync_reg[1];
  assign addr_full = {sh_reg[22:0], bit_in};
  assign page_raw  = addr_full[flash_decode_pkg::PAGE_MSB_POS -: flash_decode_pkg::PAGE_W];
  assign op_no_addr = (addr_full[7:0] == flash_decode_pkg::OP_ID_READ) ||
                      (addr_full[7:0] == flash_decode_pkg::OP_DEEP_DOWN) ||
                      (addr_full[7:0] == flash_decode_pkg::OP_RESUME) ||
                      (addr_full[7:0] == flash_decode_pkg::OP_STATUS);

  ////////////////////////////////////////////////////////////
  // page mask: buffer-only opcodes drop all, block/sector keep top bits
  always_comb begin
    page_mask = 12'hfff;
    unique case (op_reg)
      flash_decode_pkg::OP_BUF1_WRITE, flash_decode_pkg::OP_BUF2_WRITE,
      flash_decode_pkg::OP_BUF1_READ_LF, flash_decode_pkg::OP_BUF2_READ_LF,
      flash_decode_pkg::OP_BUF1_READ, flash_decode_pkg::OP_BUF2_READ: page_mask = 12'h000;
      flash_decode_pkg::OP_BLOCK_ERASE: page_mask = ~(12'hfff >> flash_decode_pkg::BLOCK_PAGE_BITS);
      flash_decode_pkg::OP_SECTOR: page_mask = ~(12'hfff >> flash_decode_pkg::SECTOR_PAGE_BITS);
      default: page_mask = 12'hfff;
    endcase
  end

  function automatic logic [2:0] dummy_of(input logic [7:0] op);
    if (op == flash_decode_pkg::OP_FAST_READ || op == flash_decode_pkg::OP_BUF1_READ ||
        op == flash_decode_pkg::OP_BUF2_READ) return flash_decode_pkg::DUMMY_ONE;
    if (op == flash_decode_pkg::OP_PAGE_READ || op == flash_decode_pkg::OP_LEGACY_READ)
      return flash_decode_pkg::DUMMY_FOUR;
    return flash_decode_pkg::DUMMY_NONE;
  endfunction

  ////////////////////////////////////////////////////////////
  always_comb begin
    cs_prev_next  = cs_sync_reg[1];
    sck_prev_next = sck_sync_reg[1];
    st_next       = st_reg;
    sh_next       = sh_reg;
    cnt_next      = cnt_reg;
    op_next       = op_reg;
    dummy_next    = dummy_reg;
    page_next     = page_reg;
    byte_next     = byte_reg;
    valid_next    = 1'b0;
    mode3_next    = mode3_reg;
    wcnt_next     = (wcnt_reg < WRITE_WAIT) ? wcnt_reg + 32'h1 : wcnt_reg;
    if (cs_fall) begin
      mode3_next = sck_sync_reg[1];
      st_next    = D_OP;
      cnt_next   = 6'h0;
    end else if (cs_rise) begin
      // a frame cut short leaves no valid pulse behind
      st_next = D_IDLE;
    end else if (sck_rise) begin
      sh_next  = addr_full;
      cnt_next = cnt_reg + 6'h1;
      unique case (st_reg)
        D_IDLE: ;
        D_OP: if (cnt_reg == 6'h7) begin
          op_next  = addr_full[7:0];
          cnt_next = 6'h0;
          if (op_no_addr) begin
            valid_next = 1'b1;
            st_next    = D_IDLE;
          end else begin
            dummy_next = dummy_of(addr_full[7:0]);
            st_next    = D_ADDR;
          end
        end
        D_ADDR: if (cnt_reg == 6'(flash_decode_pkg::ADDR_BITS - 1)) begin
          page_next = page_raw & page_mask;
          byte_next = addr_full[flash_decode_pkg::BYTE_MSB_POS:0];
          cnt_next  = 6'h0;
          if (dummy_reg == flash_decode_pkg::DUMMY_NONE) begin
            valid_next = 1'b1;
            st_next    = D_IDLE;
          end else st_next = D_DUMMY;
        end
        D_DUMMY: if (cnt_reg == 6'({dummy_reg, 3'h0} - 6'h1)) begin
          valid_next = 1'b1;
          st_next    = D_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      por_sync_reg <= 2'h0;
      cs_sync_reg  <= 2'h3;
      sck_sync_reg <= 2'h3;
      si_sync_reg  <= 2'h0;
      cs_prev_reg  <= 1'b1;
      sck_prev_reg <= 1'b1;
      st_reg       <= D_IDLE;
      sh_reg       <= 24'h0;
      cnt_reg      <= 6'h0;
      op_reg       <= 8'h0;
      dummy_reg    <= 3'h0;
      page_reg     <= 12'h0;
      byte_reg     <= 10'h0;
      valid_reg    <= 1'b0;
      mode3_reg    <= 1'b1;
      wcnt_reg     <= 32'h0;
    end else if (ce_i) begin
      por_sync_reg <= por_sync_next;
      cs_sync_reg  <= cs_sync_next;
      sck_sync_reg <= sck_sync_next;
      si_sync_reg  <= si_sync_next;
      if (por_sync_reg[1]) begin
        // frame state, valid, mode and write counter held idle while power-on reset stands
        cs_prev_reg <= 1'b1;
        st_reg      <= D_IDLE;
        valid_reg   <= 1'b0;
        mode3_reg   <= 1'b1;
        wcnt_reg    <= 32'h0;
      end else begin
        cs_prev_reg  <= cs_prev_next;
        sck_prev_reg <= sck_prev_next;
        st_reg       <= st_next;
        sh_reg       <= sh_next;
        cnt_reg      <= cnt_next;
        op_reg       <= op_next;
        dummy_reg    <= dummy_next;
        page_reg     <= page_next;
        byte_reg     <= byte_next;
        valid_reg    <= valid_next;
        mode3_reg    <= mode3_next;
        wcnt_reg     <= wcnt_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  assign link.so_o   = 1'b0;
  assign link.so_oe  = 1'b0;
  assign opcode_o    = op_reg;
  assign page_o      = page_reg;
  assign byte_o      = byte_reg;
  assign cmd_valid_o = valid_reg;
  assign mode3_o     = mode3_reg;
  assign write_ok_o  = (wcnt_reg >= WRITE_WAIT);
  assign standby_o   = (st_reg == D_IDLE) & cs_sync_reg[1];
endmodule
`default_nettype wire

// ---- verification/flash_link_checker.sv ----
// Purpose: link checks between host end and decoder end
// Assumes: link sampled on mclk_i, reset_i async high
// Notes:   host instance built with a select wait of 8
`timescale 1ns/1ps
`default_nettype none
module flash_link_checker (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_oe
);
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  property p_rst; $fell(reset_i) |-> cs_n && sck && !so_oe; endproperty
  a_rst: assert property (p_rst) else $error("link not idle after reset");
  property p_wait; $fell(reset_i) |-> cs_n [*8]; endproperty
  a_wait: assert property (p_wait) else $error("select too soon after reset");
  property p_hiz; cs_n |-> !so_oe; endproperty
  a_hiz: assert property (p_hiz) else $error("output driven while deselected");
  property p_si; !cs_n && !$past(cs_n) && $changed(si) |-> !sck; endproperty
  a_si: assert property (p_si) else $error("data moved while clock high");
  property p_hi; !cs_n && $rose(sck) |-> sck [*4]; endproperty
  a_hi: assert property (p_hi) else $error("clock high phase short");
  property p_lo; !cs_n && $fell(sck) |-> !sck [*4]; endproperty
  a_lo: assert property (p_lo) else $error("clock low phase short");
  property p_sel; $fell(cs_n) |=> $stable(sck) [*2]; endproperty
  a_sel: assert property (p_sel) else $error("clock moved at select");
  property p_len; $fell(cs_n) |-> ##[60:600] $rose(cs_n); endproperty
  a_len: assert property (p_len) else $error("frame length out of range");
endmodule
`default_nettype wire

// ---- verification/serial_flash_addr_decode_por_test.sv ----
// Purpose: self-checking bench for host end and decoder end
// Assumes: shortened power-up waits, 320 ns link clock
// Notes:   expected fields worked out from the opcode table
`timescale 1ns/1ps
`default_nettype none
module serial_flash_addr_decode_por_test;
  logic        mclk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        start = 1'b0, idle_high = 1'b1, por = 1'b0;
  logic        ready, done, valid, mode3, wok, stby;
  logic [7:0]  op = 8'h00, dev_op;
  logic [23:0] addr = 24'h000000;
  logic [2:0]  dummy = 3'h0;
  logic [11:0] page;
  logic [9:0]  byte_off;
  int          n_fail = 0, num_checks = 0;
  logic [7:0]  ops [30] = '{8'h03, 8'h0b, 8'h50, 8'h53, 8'h55, 8'h58, 8'h59, 8'h60, 8'h61, 8'h77, 8'h7c,
    8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h9f, 8'hb9, 8'hab, 8'hd1, 8'hd2,
    8'hd3, 8'hd4, 8'hd6, 8'hd7, 8'he8};
  always #20 mclk_i = ~mclk_i;
  flash_link_if link_if ();
  flash_host_end #(.SELECT_WAIT(8)) flash_host_end_inst (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(1'b1),
    .link(link_if.host), .start_i(start), .idle_high_i(idle_high), .opcode_i(op), .addr_i(addr),
    .dummy_i(dummy), .ready_o(ready), .done_o(done));
  flash_decode_dev #(.WRITE_WAIT(50)) flash_decode_dev_inst (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(1'b1),
    .por_i(por), .link(link_if.device), .opcode_o(dev_op), .page_o(page), .byte_o(byte_off),
    .cmd_valid_o(valid), .mode3_o(mode3), .write_ok_o(wok), .standby_o(stby));
  flash_link_checker flash_link_checker_inst (.mclk_i(mclk_i), .reset_i(reset_i), .cs_n(link_if.cs_n),
    .sck(link_if.sck), .si(link_if.si), .so_oe(link_if.so_oe));
  ////////////////////////////////////////////////////////////
  function automatic logic [11:0] exp_page(input logic [7:0] o, input logic [23:0] a);
    if (o inside {8'h84, 8'h87, 8'hd1, 8'hd3, 8'hd4, 8'hd6}) return 12'h000;
    if (o == 8'h50) return a[21:10] & 12'hff8;
    if (o == 8'h7c) return a[21:10] & 12'hf00;
    return a[21:10];
  endfunction
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one whole frame through the host end; ex says whether a decode is due
  task automatic run_cmd(input logic [7:0] o, input logic [23:0] a, input logic m3, input logic ex);
    logic seen;
    int d;
    seen = 1'b0;
    d = 1000;
    idle_high <= m3;
    @(posedge mclk_i);
    for (int k = 0; k < 2000 && ready !== 1'b1; k++) @(posedge mclk_i);
    op <= o;
    addr <= a;
    dummy <= (o inside {8'h0b, 8'hd4, 8'hd6}) ? 3'h1 : (o inside {8'hd2, 8'he8}) ? 3'h4 : 3'h0;
    start <= 1'b1;
    for (int k = 0; k < 900 && k <= d + 8; k++) begin
      @(posedge mclk_i);
      start <= 1'b0;
      if (done === 1'b1) d = k;
      if (valid === 1'b1 && !seen) begin
        seen = 1'b1;
        check(24'(dev_op), 24'(o));
        if (!(o inside {8'h9f, 8'hb9, 8'hab, 8'hd7, 8'h77})) check(24'(page), 24'(exp_page(o, a)));
        if (o inside {8'h03, 8'h0b, 8'h82, 8'h84, 8'h85, 8'h87, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd6, 8'he8})
          check(24'(byte_off), 24'(a[9:0]));
        check(24'(mode3), 24'(m3));
      end
    end
    check(24'(d < 1000), 24'h000001);
    check(24'(seen), 24'(ex));
  endtask
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge mclk_i);
    n_fail++;
    complete_run();
  end
  initial begin
    logic [7:0]  o;
    logic [23:0] a;
    void'($urandom(32'h713b));
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    check(24'(mode3), 24'h000001);
    check(24'(stby), 24'h000001);
    check(24'(link_if.so_oe), 24'h000000);
    check(24'(wok), 24'h000000);
    // program and erase opcodes wait for the power-up write delay
    for (int k = 0; k < 200 && wok !== 1'b1; k++) @(posedge mclk_i);
    check(24'(wok), 24'h000001);
    $display("test power-up state done");
    for (int i = 0; i < 40; i++) begin
      o = (i < 30) ? ops[i] : ops[$urandom_range(29, 0)];
      a = (i < 2) ? {24{i[0]}} : 24'($urandom);
      run_cmd(o, a, (i < 2) ? i[0] : 1'($urandom), 1'b1);
    end
    $display("test command table done");
    por <= 1'b1;
    run_cmd(8'h0b, 24'h2aaaaa, 1'b1, 1'b0);
    por <= 1'b0;
    repeat (8) @(posedge mclk_i);
    run_cmd(8'hd2, 24'h155555, 1'b0, 1'b1);
    check(24'(wok), 24'h000001);
    check(24'(stby), 24'h000001);
    $display("test power-on reset done");
    complete_run();
  end
endmodule
`default_nettype wire
